// ==== shared/cpr_pkg.sv ====
// constants and types of the programmer register file and flag logic
package cpr_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int unsigned CPR_AW = 4;
  localparam int unsigned CPR_DW = 16;
  localparam logic [3:0] CPR_IDX_ACC_HI = 4'h0;
  localparam logic [3:0] CPR_IDX_ACC_LO = 4'h1;
  localparam logic [3:0] CPR_IDX_PAIRED = 4'h2;
  localparam logic [3:0] CPR_IDX_PTR1 = 4'h3;
  localparam logic [3:0] CPR_IDX_PTR2 = 4'h4;
  localparam logic [3:0] CPR_IDX_PSTK = 4'h5;
  localparam logic [3:0] CPR_IDX_HSTK = 4'h6;
  localparam logic [3:0] CPR_IDX_NIP = 4'h7;
  localparam logic [3:0] CPR_IDX_PAGE = 4'h8;
  localparam logic [3:0] CPR_IDX_FLAGS = 4'h9;

  // ----------------------------------------------------------------
  // flag byte layout
  // ----------------------------------------------------------------
  localparam int unsigned CPR_F_CARRY = 0;
  localparam int unsigned CPR_F_OVFL = 1;
  localparam int unsigned CPR_F_ZERO = 2;
  localparam int unsigned CPR_F_NEG = 3;
  localparam int unsigned CPR_F_IMASK = 4;
  localparam int unsigned CPR_F_HALF = 5;
  localparam int unsigned CPR_F_QMASK = 6;
  localparam int unsigned CPR_F_ENTIRE = 7;

  // ----------------------------------------------------------------
  // reset values and stacking sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] CPR_RST_PAGE = 8'h00;
  localparam logic [7:0] CPR_RST_FLAGS = 8'h50;
  localparam logic [7:0] CPR_RST_BYTE = 8'h00;
  localparam logic [15:0] CPR_RST_WORD = 16'h0000;
  localparam logic [3:0] CPR_STK_FULL = 4'hc;
  localparam logic [3:0] CPR_STK_SHORT = 4'h3;

  // ----------------------------------------------------------------
  // operations and pointer selects
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CPR_OP_NONE = 4'h0,
    CPR_OP_ADD = 4'h1,
    CPR_OP_ADC = 4'h2,
    CPR_OP_SUB = 4'h3,
    CPR_OP_SBC = 4'h4,
    CPR_OP_AND = 4'h5,
    CPR_OP_OR = 4'h6,
    CPR_OP_EOR = 4'h7,
    CPR_OP_LD = 4'h8,
    CPR_OP_MUL = 4'h9,
    CPR_OP_DAA = 4'ha,
    CPR_OP_ADDW = 4'hb,
    CPR_OP_SUBW = 4'hc
  } cpr_op_e;

  typedef enum logic [2:0] {
    CPR_BASE_PTR1 = 3'h0,
    CPR_BASE_PTR2 = 3'h1,
    CPR_BASE_PSTK = 3'h2,
    CPR_BASE_HSTK = 3'h3,
    CPR_BASE_NIP = 3'h4
  } cpr_base_e;

endpackage

// ==== core/cpr_regs.sv ====
// programmer register file, flag logic and interrupt masks
// ----------------------------------------------------------------
// Functional notes
// (RULE1) direct address is page byte joined with the byte after the opcode
// (RULE2) page byte drives address bits fifteen down to eight
// (RULE3) reset clears the page register
// (RULE4) both accumulators pair into one word, high accumulator on top
// (RULE5) half carry at bit 5 records carry out of bit three on add
// (RULE6) half carry left untouched by subtracts, its value is free
// (RULE7) negative at bit 3 copies the result msb
// (RULE8) zero at bit 2 set when result is zero, else cleared
// (RULE9) overflow at bit 1 flags signed overflow
// (RULE10) carry at bit 0 records carry or borrow out of bit seven
// (RULE11) a set mask stops its request from being recognised
// (RULE12) quick mask at bit 6 set by reset, interrupt entry, soft trap
// (RULE13) normal mask at bit 4 set by reset, interrupt entry, soft trap
// (RULE14) entire flag at bit 7 tells full or short stacking
// (RULE15) return reads entire flag of pulled byte to pick restore size
// (RULE16) quick request stacks only pointer and flags
// (RULE17) product op multiplies accumulators unsigned into the pair
// (RULE18) bcd adjust uses half carry to correct the accumulator
// (RULE19) hardware stack used automatically, still writable by software
// (RULE20) stack pointers address the top entry, not the next free byte
// (RULE21) instruction pointer holds next address, usable as index base
// (RULE22) branch displacement spans the whole signed 16-bit range
// (RULE23) flags not defined by an operation keep their value
// ----------------------------------------------------------------
`timescale 1ns/1ns
module cpr_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register bus
  input wire logic [cpr_pkg::CPR_AW-1:0] reg_addr,
  input wire logic [cpr_pkg::CPR_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [cpr_pkg::CPR_DW-1:0] reg_rdata,
  // data operations
  input wire cpr_pkg::cpr_op_e op_code,
  input wire logic op_dst_lo,
  input wire logic [7:0] op_byte,
  input wire logic [15:0] op_word,
  // addressing
  input wire logic [7:0] dir_offset,
  output logic [15:0] dir_addr,
  input wire cpr_pkg::cpr_base_e base_sel,
  output logic [15:0] base_addr,
  // instruction pointer
  input wire logic pc_step,
  input wire logic [2:0] pc_bytes,
  input wire logic br_take,
  input wire logic [15:0] br_disp,
  // hardware stack moves
  input wire logic stk_push,
  input wire logic stk_pull,
  input wire logic [3:0] stk_bytes,
  output logic [15:0] stk_top,
  // interrupts
  input wire logic normal_req_in,
  input wire logic quick_request_in,
  output logic normal_accept,
  output logic quick_accept,
  input wire logic svc_enter,
  input wire logic svc_short,
  input wire logic soft_trap,
  input wire logic return_from_service,
  input wire logic [7:0] pulled_flags,
  output logic restore_all,
  output logic [3:0] stack_count,
  // flag view
  output logic [7:0] flags_out
);
  import cpr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] acc_hi_q, acc_hi_d;
  logic [7:0] acc_lo_q, acc_lo_d;
  logic [15:0] ptr1_q, ptr1_d;
  logic [15:0] ptr2_q, ptr2_d;
  logic [15:0] pstk_q, pstk_d;
  logic [15:0] hstk_q, hstk_d;
  logic [15:0] nip_q, nip_d;
  logic [7:0] page_q, page_d;
  logic [7:0] flags_q, flags_d;
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] dir_q, dir_d;
  logic [15:0] base_q, base_d;
  logic restore_q, restore_d;
  logic [3:0] count_q, count_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] pick_base(
    input cpr_base_e sel,
    input logic [15:0] p1,
    input logic [15:0] p2,
    input logic [15:0] ps,
    input logic [15:0] hs,
    input logic [15:0] ip
  );
    logic [15:0] r;
    r = ip;
    unique case (sel)
      CPR_BASE_PTR1: r = p1;
      CPR_BASE_PTR2: r = p2;
      CPR_BASE_PSTK: r = ps;
      CPR_BASE_HSTK: r = hs;
      CPR_BASE_NIP: r = ip;
      default: r = ip;
    endcase
    return r;
  endfunction

  // true when a bus write targets the given register index
  function automatic logic bus_hit(
    input logic wr,
    input logic [3:0] addr,
    input logic [3:0] idx
  );
    return wr && (addr == idx);
  endfunction

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  logic [7:0] src8;
  logic [15:0] paired;
  logic [8:0] sum9;
  logic [4:0] low5;
  logic [7:0] res8;
  logic [16:0] sum17;
  logic [15:0] prod16;
  logic [7:0] bcd_fix;
  logic [8:0] bcd9;
  logic bcd_carry;
  logic cin;

  always_comb begin
    src8 = op_dst_lo ? acc_lo_q : acc_hi_q;
    paired = {acc_hi_q, acc_lo_q}; // RULE4
    cin = flags_q[CPR_F_CARRY];
    sum9 = 9'h000;
    low5 = 5'h00;
    res8 = 8'h00;
    sum17 = 17'h00000;
    prod16 = 16'({8'h00, acc_hi_q} * {8'h00, acc_lo_q}); // RULE17
    bcd_fix = 8'h00;
    bcd_carry = 1'b0;
    // lower digit fixed on half carry or digit above nine
    if (flags_q[CPR_F_HALF] || (acc_hi_q[3:0] > 4'h9)) begin // RULE18
      bcd_fix[3:0] = 4'h6;
    end
    if (cin || (acc_hi_q[7:4] > 4'h9) ||
        ((acc_hi_q[7:4] > 4'h8) && (acc_hi_q[3:0] > 4'h9))) begin
      bcd_fix[7:4] = 4'h6;
      bcd_carry = 1'b1;
    end
    bcd9 = {1'b0, acc_hi_q} + {1'b0, bcd_fix};
    unique case (op_code)
      CPR_OP_ADD, CPR_OP_ADC: begin
        sum9 = {1'b0, src8} + {1'b0, op_byte} +
          {8'h00, (op_code == CPR_OP_ADC) & cin};
        low5 = {1'b0, src8[3:0]} + {1'b0, op_byte[3:0]} +
          {4'h0, (op_code == CPR_OP_ADC) & cin};
        res8 = sum9[7:0];
      end
      CPR_OP_SUB, CPR_OP_SBC: begin
        sum9 = {1'b0, src8} - {1'b0, op_byte} -
          {8'h00, (op_code == CPR_OP_SBC) & cin};
        res8 = sum9[7:0];
      end
      CPR_OP_AND: res8 = src8 & op_byte;
      CPR_OP_OR: res8 = src8 | op_byte;
      CPR_OP_EOR: res8 = src8 ^ op_byte;
      CPR_OP_LD: res8 = op_byte;
      CPR_OP_DAA: res8 = bcd9[7:0];
      CPR_OP_ADDW: sum17 = {1'b0, paired} + {1'b0, op_word};
      CPR_OP_SUBW: sum17 = {1'b0, paired} - {1'b0, op_word};
      default: res8 = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [3:0] svc_count;

  always_comb begin
    acc_hi_d = acc_hi_q;
    acc_lo_d = acc_lo_q;
    ptr1_d = ptr1_q;
    ptr2_d = ptr2_q;
    pstk_d = pstk_q;
    hstk_d = hstk_q;
    nip_d = nip_q;
    page_d = page_q;
    flags_d = flags_q; // RULE23
    restore_d = restore_q;
    count_d = count_q;
    svc_count = svc_short ? CPR_STK_SHORT : CPR_STK_FULL; // RULE16

    // data operations
    unique case (op_code)
      CPR_OP_ADD, CPR_OP_ADC: begin
        flags_d[CPR_F_HALF] = low5[4]; // RULE5
        flags_d[CPR_F_CARRY] = sum9[8]; // RULE10
        flags_d[CPR_F_OVFL] = (src8[7] == op_byte[7]) &&
          (res8[7] != src8[7]); // RULE9
      end
      CPR_OP_SUB, CPR_OP_SBC: begin
        // half carry kept as is, any value is allowed here
        flags_d[CPR_F_CARRY] = sum9[8]; // RULE6 RULE10
        flags_d[CPR_F_OVFL] = (src8[7] != op_byte[7]) &&
          (res8[7] != src8[7]); // RULE9
      end
      CPR_OP_AND, CPR_OP_OR, CPR_OP_EOR, CPR_OP_LD:
        flags_d[CPR_F_OVFL] = 1'b0; // RULE9
      CPR_OP_DAA:
        flags_d[CPR_F_CARRY] = cin | bcd_carry | bcd9[8]; // RULE10
      default: ;
    endcase
    if (op_code inside {CPR_OP_ADD, CPR_OP_ADC, CPR_OP_SUB, CPR_OP_SBC,
        CPR_OP_AND, CPR_OP_OR, CPR_OP_EOR, CPR_OP_LD, CPR_OP_DAA}) begin
      flags_d[CPR_F_NEG] = res8[7]; // RULE7
      flags_d[CPR_F_ZERO] = (res8 == 8'h00); // RULE8
      if (op_dst_lo && (op_code != CPR_OP_DAA)) begin
        acc_lo_d = res8;
      end else begin
        acc_hi_d = res8;
      end
    end
    if (op_code == CPR_OP_MUL) begin
      {acc_hi_d, acc_lo_d} = prod16; // RULE17 RULE4
      flags_d[CPR_F_ZERO] = (prod16 == 16'h0000); // RULE8
      flags_d[CPR_F_CARRY] = prod16[7];
    end
    if (op_code inside {CPR_OP_ADDW, CPR_OP_SUBW}) begin
      {acc_hi_d, acc_lo_d} = sum17[15:0]; // RULE4
      flags_d[CPR_F_NEG] = sum17[15]; // RULE7
      flags_d[CPR_F_ZERO] = (sum17[15:0] == 16'h0000); // RULE8
      flags_d[CPR_F_CARRY] = sum17[16];
      flags_d[CPR_F_OVFL] = (op_code == CPR_OP_ADDW) ?
        ((paired[15] == op_word[15]) && (sum17[15] != paired[15])) :
        ((paired[15] != op_word[15]) && (sum17[15] != paired[15])); // RULE9
    end

    // instruction pointer
    if (br_take) begin
      nip_d = nip_q + br_disp; // RULE22
    end else if (pc_step) begin
      nip_d = nip_q + {13'h0000, pc_bytes}; // RULE21
    end

    // hardware stack, always pointing at the last byte pushed
    if (svc_enter) begin
      hstk_d = hstk_q - {12'h000, svc_count}; // RULE19 RULE20
      count_d = svc_count;
      flags_d[CPR_F_ENTIRE] = !svc_short; // RULE14
      flags_d[CPR_F_IMASK] = 1'b1; // RULE13
      flags_d[CPR_F_QMASK] = 1'b1; // RULE12
    end else if (return_from_service) begin
      flags_d = pulled_flags;
      restore_d = pulled_flags[CPR_F_ENTIRE]; // RULE15
      count_d = pulled_flags[CPR_F_ENTIRE] ? CPR_STK_FULL : CPR_STK_SHORT;
      hstk_d = hstk_q + {12'h000, count_d}; // RULE15 RULE20
    end else if (stk_push) begin
      hstk_d = hstk_q - {12'h000, stk_bytes}; // RULE20
    end else if (stk_pull) begin
      hstk_d = hstk_q + {12'h000, stk_bytes}; // RULE20
    end
    if (soft_trap) begin
      flags_d[CPR_F_IMASK] = 1'b1; // RULE13
      flags_d[CPR_F_QMASK] = 1'b1; // RULE12
    end

    // software loads come last so a program write always lands
    if (bus_hit(reg_wr, reg_addr, CPR_IDX_ACC_HI)) acc_hi_d = reg_wdata[7:0];
    if (bus_hit(reg_wr, reg_addr, CPR_IDX_ACC_LO)) acc_lo_d = reg_wdata[7:0];
    if (bus_hit(reg_wr, reg_addr, CPR_IDX_PAIRED)) begin
      {acc_hi_d, acc_lo_d} = reg_wdata; // RULE4
    end
    if (bus_hit(reg_wr, reg_addr, CPR_IDX_PTR1)) ptr1_d = reg_wdata;
    if (bus_hit(reg_wr, reg_addr, CPR_IDX_PTR2)) ptr2_d = reg_wdata;
    if (bus_hit(reg_wr, reg_addr, CPR_IDX_PSTK)) pstk_d = reg_wdata;
    if (bus_hit(reg_wr, reg_addr, CPR_IDX_HSTK)) hstk_d = reg_wdata; // RULE19
    if (bus_hit(reg_wr, reg_addr, CPR_IDX_NIP)) nip_d = reg_wdata;
    if (bus_hit(reg_wr, reg_addr, CPR_IDX_PAGE)) page_d = reg_wdata[7:0];
    if (bus_hit(reg_wr, reg_addr, CPR_IDX_FLAGS)) flags_d = reg_wdata[7:0];
  end

  // ----------------------------------------------------------------
  // read port and address outputs
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        CPR_IDX_ACC_HI: rdata_d = {8'h00, acc_hi_q};
        CPR_IDX_ACC_LO: rdata_d = {8'h00, acc_lo_q};
        CPR_IDX_PAIRED: rdata_d = {acc_hi_q, acc_lo_q}; // RULE4
        CPR_IDX_PTR1: rdata_d = ptr1_q;
        CPR_IDX_PTR2: rdata_d = ptr2_q;
        CPR_IDX_PSTK: rdata_d = pstk_q;
        CPR_IDX_HSTK: rdata_d = hstk_q;
        CPR_IDX_NIP: rdata_d = nip_q;
        CPR_IDX_PAGE: rdata_d = {8'h00, page_q};
        CPR_IDX_FLAGS: rdata_d = {8'h00, flags_q};
        default: rdata_d = 16'h0000;
      endcase
    end
    dir_d = {page_q, dir_offset}; // RULE1 RULE2
    base_d = pick_base(base_sel, ptr1_q, ptr2_q, pstk_q, hstk_q,
      nip_q); // RULE21
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      acc_hi_q <= CPR_RST_BYTE;
      acc_lo_q <= CPR_RST_BYTE;
      ptr1_q <= CPR_RST_WORD;
      ptr2_q <= CPR_RST_WORD;
      pstk_q <= CPR_RST_WORD;
      hstk_q <= CPR_RST_WORD;
      nip_q <= CPR_RST_WORD;
      page_q <= CPR_RST_PAGE; // RULE3
      flags_q <= CPR_RST_FLAGS; // RULE12 RULE13
      rdata_q <= CPR_RST_WORD;
      dir_q <= CPR_RST_WORD;
      base_q <= CPR_RST_WORD;
      restore_q <= 1'b0;
      count_q <= 4'h0;
    end else begin
      acc_hi_q <= acc_hi_d;
      acc_lo_q <= acc_lo_d;
      ptr1_q <= ptr1_d;
      ptr2_q <= ptr2_d;
      pstk_q <= pstk_d;
      hstk_q <= hstk_d;
      nip_q <= nip_d;
      page_q <= page_d;
      flags_q <= flags_d;
      rdata_q <= rdata_d;
      dir_q <= dir_d;
      base_q <= base_d;
      restore_q <= restore_d;
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // recognition is combinational so the sequencer sees it this cycle
  assign normal_accept = normal_req_in && !flags_q[CPR_F_IMASK]; // RULE11
  assign quick_accept = quick_request_in && !flags_q[CPR_F_QMASK]; // RULE11
  assign reg_rdata = rdata_q;
  assign dir_addr = dir_q;
  assign base_addr = base_q;
  assign stk_top = hstk_q;
  assign restore_all = restore_q;
  assign stack_count = count_q;
  assign flags_out = flags_q;

endmodule // cpr_regs

// ==== dv/cpr_regs_asserts.sv ====
// concurrent checks on the register file and flag logic ports
`timescale 1ns/1ns
module cpr_regs_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register bus
  input wire logic [cpr_pkg::CPR_AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [cpr_pkg::CPR_DW-1:0] reg_rdata,
  // operations and addressing
  input wire cpr_pkg::cpr_op_e op_code,
  input wire logic [7:0] op_byte,
  input wire logic [7:0] dir_offset,
  input wire logic [15:0] dir_addr,
  input wire logic [15:0] stk_top,
  // interrupts
  input wire logic normal_req_in,
  input wire logic quick_request_in,
  input wire logic normal_accept,
  input wire logic quick_accept,
  input wire logic svc_enter,
  input wire logic svc_short,
  input wire logic soft_trap,
  input wire logic return_from_service,
  input wire logic [7:0] pulled_flags,
  input wire logic restore_all,
  input wire logic [3:0] stack_count,
  input wire logic [7:0] flags_out
);
  import cpr_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // bus writes to the flag byte win over core updates
  logic fw;
  assign fw = reg_wr && (reg_addr == CPR_IDX_FLAGS);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_reset_state: assert property (
    $rose(rst_n) |-> flags_out == 8'h50 && dir_addr[15:8] == 8'h00)
    else $error("flag byte or page wrong after reset");
  chk_dir_low: assert property (
    1'b1 |=> dir_addr[7:0] == $past(dir_offset))
    else $error("direct address low byte wrong");
  chk_accept_norm: assert property (
    normal_accept == (normal_req_in && !flags_out[CPR_F_IMASK]))
    else $error("normal accept ignores its mask");
  chk_accept_quick: assert property (
    quick_accept == (quick_request_in && !flags_out[CPR_F_QMASK]))
    else $error("quick accept ignores its mask");
  chk_entry_flags: assert property (
    svc_enter && !fw |=> flags_out[7:6] == {!$past(svc_short), 1'b1}
    && flags_out[4] && stack_count ==
    ($past(svc_short) ? CPR_STK_SHORT : CPR_STK_FULL))
    else $error("entry flags or count wrong");
  chk_short_stack: assert property (
    svc_enter && svc_short && !reg_wr |=>
    stk_top == $past(stk_top) - 16'h0003)
    else $error("short entry stacked wrong size");
  chk_return_pick: assert property (
    return_from_service && !svc_enter && !fw |=>
    restore_all == $past(pulled_flags[7]) && stack_count ==
    ($past(pulled_flags[7]) ? CPR_STK_FULL : CPR_STK_SHORT))
    else $error("return restore size wrong");
  chk_trap_masks: assert property (
    soft_trap && !fw |=> flags_out[6] && flags_out[4])
    else $error("soft trap left a mask clear");
  chk_load_flags: assert property (
    op_code == CPR_OP_LD && !fw && !svc_enter && !return_from_service
    |=> flags_out[3:2] == {$past(op_byte[7]), $past(op_byte) == 8'h00})
    else $error("load result flags wrong");
  chk_flags_hold: assert property (
    op_code == CPR_OP_NONE && !reg_wr && !svc_enter && !soft_trap
    && !return_from_service |=> $stable(flags_out))
    else $error("flags moved with no cause");
  chk_rdata_idle: assert property (
    !reg_rd || reg_addr > CPR_IDX_FLAGS |=> reg_rdata == 16'h0000)
    else $error("read data not zero when idle");
endmodule // cpr_regs_asserts

// ==== dv/tb.sv ====
// self-checking bench for the register file and flag logic
`timescale 1ns/1ns
module tb;
  import cpr_pkg::*;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, op_dst_lo = 0;
  logic [3:0] reg_addr = 0, stk_bytes = 0;
  logic [15:0] reg_wdata = 0, op_word = 0, br_disp = 0, reg_rdata;
  logic [15:0] dir_addr, base_addr, stk_top;
  cpr_op_e op_code = CPR_OP_NONE;
  cpr_base_e base_sel = CPR_BASE_PTR1;
  logic [7:0] op_byte = 0, dir_offset = 0, pulled_flags = 0, flags_out;
  logic [2:0] pc_bytes = 0;
  logic pc_step = 0, br_take = 0, stk_push = 0, stk_pull = 0;
  logic normal_req_in = 0, quick_request_in = 0, svc_enter = 0;
  logic svc_short = 0, soft_trap = 0, return_from_service = 0;
  logic normal_accept, quick_accept, restore_all;
  logic [3:0] stack_count;
  int bad_count = 0, compares = 0, cyc = 0, i;
  cpr_regs i_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .op_code, .op_dst_lo, .op_byte, .op_word,
    .dir_offset, .dir_addr, .base_sel, .base_addr, .pc_step, .pc_bytes,
    .br_take, .br_disp, .stk_push, .stk_pull, .stk_bytes, .stk_top,
    .normal_req_in, .quick_request_in, .normal_accept, .quick_accept,
    .svc_enter, .svc_short, .soft_trap, .return_from_service,
    .pulled_flags, .restore_all, .stack_count, .flags_out);
  always #50 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // hang guard, whole run is a few hundred cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ends every one-cycle pulse at the edge that takes it
  task automatic tick;
    @(posedge clk_sys);
    reg_wr <= 0; reg_rd <= 0; op_code <= CPR_OP_NONE; pc_step <= 0;
    br_take <= 0; stk_push <= 0; stk_pull <= 0; svc_enter <= 0;
    soft_trap <= 0; return_from_service <= 0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
    tick;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a; reg_rd <= 1;
    tick;
    @(negedge clk_sys) chk(reg_rdata, exp);
  endtask
  // preset flags and pair, then run one operation
  task automatic op8(input logic [7:0] pf, input logic [15:0] ab,
      input cpr_op_e o, input logic [7:0] v, input logic [15:0] ep,
      input logic [7:0] ef, m);
    wr(CPR_IDX_FLAGS, {8'h00, pf});
    wr(CPR_IDX_PAIRED, ab);
    @(posedge clk_sys);
    op_code <= o; op_byte <= v;
    tick;
    @(negedge clk_sys) chk({8'h00, flags_out & m}, {8'h00, ef & m});
    rd(CPR_IDX_PAIRED, ep);
  endtask
  task automatic svc(input logic [7:0] f, input logic [3:0] n,
      input logic r, input logic [15:0] s);
    tick;
    @(negedge clk_sys) chk({8'h00, flags_out}, {8'h00, f});
    chk({12'h000, stack_count}, {12'h000, n});
    chk({15'h0000, restore_all}, {15'h0000, r});
    chk(stk_top, s);
    rd(CPR_IDX_HSTK, s);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    for (i = 0; i < 10; i++) begin
      rd(4'(i), (i == 9) ? {8'h00, CPR_RST_FLAGS} : 16'h0000);
    end
    rd(4'hf, 16'h0000);
    wr(CPR_IDX_ACC_HI, 16'h0012);
    wr(CPR_IDX_ACC_LO, 16'h0034);
    rd(CPR_IDX_PAIRED, 16'h1234);
    wr(CPR_IDX_PAIRED, 16'habcd);
    rd(CPR_IDX_ACC_HI, 16'h00ab);
    rd(CPR_IDX_ACC_LO, 16'h00cd);
    wr(CPR_IDX_PAGE, 16'h005a);
    @(posedge clk_sys) dir_offset <= 8'h3c;
    @(posedge clk_sys);
    @(negedge clk_sys) chk(dir_addr, 16'h5a3c);
    op8(8'h50, 16'h0800, CPR_OP_ADD, 8'h08, 16'h1000, 8'h70, 8'hff);
    op8(8'h50, 16'h7f00, CPR_OP_ADD, 8'h01, 16'h8000, 8'h7a, 8'hff);
    op8(8'h50, 16'hff00, CPR_OP_ADD, 8'h01, 16'h0000, 8'h75, 8'hff);
    op8(8'h50, 16'h0000, CPR_OP_SUB, 8'h01, 16'hff00, 8'h59, 8'hdf);
    op8(8'h50, 16'h8000, CPR_OP_SUB, 8'h01, 16'h7f00, 8'h52, 8'hdf);
    op8(8'h51, 16'h3300, CPR_OP_LD, 8'h00, 16'h0000, 8'h55, 8'hff);
    op8(8'h50, 16'h0c0c, CPR_OP_MUL, 8'h00, 16'h0090, 8'h51, 8'hff);
    op8(8'h50, 16'hffff, CPR_OP_MUL, 8'h00, 16'hfe01, 8'h50, 8'hff);
    op8(8'h70, 16'h1000, CPR_OP_DAA, 8'h00, 16'h1600, 8'h00, 8'h0d);
    op8(8'h50, 16'h1000, CPR_OP_DAA, 8'h00, 16'h1000, 8'h00, 8'h0d);
    // low accumulator as target, carry fed in
    @(posedge clk_sys) op_dst_lo <= 1;
    op8(8'h51, 16'h1234, CPR_OP_ADC, 8'h0b, 16'h1240, 8'h70, 8'hff);
    op8(8'h51, 16'h1210, CPR_OP_SBC, 8'h0f, 16'h1200, 8'h54, 8'hdf);
    @(posedge clk_sys) op_dst_lo <= 0;
    op8(8'h53, 16'hf000, CPR_OP_AND, 8'h9c, 16'h9000, 8'h59, 8'hff);
    op8(8'h50, 16'h0f00, CPR_OP_OR, 8'h80, 16'h8f00, 8'h58, 8'hff);
    op8(8'h50, 16'ha500, CPR_OP_EOR, 8'ha5, 16'h0000, 8'h54, 8'hff);
    @(posedge clk_sys) op_word <= 16'h0001;
    op8(8'h50, 16'h7fff, CPR_OP_ADDW, 8'h00, 16'h8000, 8'h5a, 8'hff);
    op8(8'h50, 16'h0000, CPR_OP_SUBW, 8'h00, 16'hffff, 8'h59, 8'hff);
    for (i = 0; i < 5; i++) begin
      wr(4'(3 + i), 16'(16'h1111 * (i + 1)));
      @(posedge clk_sys) base_sel <= cpr_base_e'(i);
      @(posedge clk_sys);
      @(negedge clk_sys) chk(base_addr, 16'(16'h1111 * (i + 1)));
    end
    @(posedge clk_sys) pc_step <= 1;
    pc_bytes <= 3'h3;
    tick;
    rd(CPR_IDX_NIP, 16'h5558);
    @(posedge clk_sys) br_take <= 1;
    pc_step <= 1;
    br_disp <= 16'h8000;
    tick;
    rd(CPR_IDX_NIP, 16'hd558);
    @(posedge clk_sys) br_take <= 1;
    br_disp <= 16'h7fff;
    tick;
    rd(CPR_IDX_NIP, 16'h5557);
    @(posedge clk_sys) stk_push <= 1;
    stk_bytes <= 4'h2;
    tick;
    rd(CPR_IDX_HSTK, 16'h4442);
    @(posedge clk_sys) stk_pull <= 1;
    tick;
    rd(CPR_IDX_HSTK, 16'h4444);
    wr(CPR_IDX_FLAGS, 16'h0000);
    @(posedge clk_sys) normal_req_in <= 1;
    quick_request_in <= 1;
    @(negedge clk_sys) chk({normal_accept, quick_accept}, 16'h0003);
    wr(CPR_IDX_FLAGS, 16'h0010);
    @(negedge clk_sys) chk({normal_accept, quick_accept}, 16'h0001);
    wr(CPR_IDX_FLAGS, 16'h0040);
    @(negedge clk_sys) chk({normal_accept, quick_accept}, 16'h0002);
    wr(CPR_IDX_HSTK, 16'h1000);
    wr(CPR_IDX_FLAGS, 16'h0000);
    @(posedge clk_sys) svc_enter <= 1;
    svc_short <= 1;
    svc(8'h50, 4'h3, 1'b0, 16'h0ffd);
    @(posedge clk_sys) svc_enter <= 1;
    svc_short <= 0;
    svc(8'hd0, 4'hc, 1'b0, 16'h0ff1);
    @(posedge clk_sys) return_from_service <= 1;
    pulled_flags <= 8'h80;
    svc(8'h80, 4'hc, 1'b1, 16'h0ffd);
    @(posedge clk_sys) return_from_service <= 1;
    pulled_flags <= 8'h01;
    svc(8'h01, 4'h3, 1'b0, 16'h1000);
    @(posedge clk_sys) soft_trap <= 1;
    svc(8'h51, 4'h3, 1'b0, 16'h1000);
    report_and_stop;
  end
endmodule // tb
bind cpr_regs cpr_regs_asserts i_chk (.clk_sys, .rst_n, .reg_addr,
  .reg_wr, .reg_rd, .reg_rdata, .op_code, .op_byte, .dir_offset,
  .dir_addr, .stk_top, .normal_req_in, .quick_request_in,
  .normal_accept, .quick_accept, .svc_enter, .svc_short, .soft_trap,
  .return_from_service, .pulled_flags, .restore_all, .stack_count,
  .flags_out);
